// ---- hw/vpm_defs.svh ----
// register offsets, field positions, reset values and timing constants
`ifndef VPM_DEFS_SVH
`define VPM_DEFS_SVH

// register byte offsets
`define VPM_A_CTRL      8'h00
`define VPM_A_DELAY     8'h04
`define VPM_A_STATUS    8'h08
`define VPM_A_ACK       8'h0C
`define VPM_A_IRQ_STAT  8'h10
`define VPM_A_IRQ_CLR   8'h14
`define VPM_A_IRQ_EN    8'h18

// control register fields
`define VPM_C_ON        0
`define VPM_C_DUAL      1
`define VPM_C_SACK      2
`define VPM_C_ACT       5:4
`define VPM_C_FSEL      12:8
`define VPM_C_CLS       18:16
`define VPM_CTRL_MASK   32'h0007_1F37
`define VPM_CTRL_RST    32'h0001_0000

// delay in seconds
`define VPM_DLY_W       10
`define VPM_DLY_RST     10'h01E
`define VPM_DLY_MIN     10'h001
`define VPM_DLY_MAX     10'h3E7

// phase angle limit in degrees
`define VPM_PH_LIM      9'sh00A

// interrupt status bits
`define VPM_NIRQ        3
`define VPM_I_RAISE     0
`define VPM_I_FAULT     1
`define VPM_I_CLEAR     2

// time base
`define VPM_SEC_NS      1000000000
`define VPM_CLK_NS      10

`endif

// ---- hw/vpm_pkg.sv ----
// types shared by the plausibility monitor
package vpm_pkg;

    // monitoring activation source
    typedef enum logic [1:0] {
        VPM_ACT_ALWAYS,
        VPM_ACT_LOCK,
        VPM_ACT_FLAG
    } vpm_act_e;

    // alarm class presented with the alarm
    typedef enum logic [2:0] {
        VPM_CLS_A,
        VPM_CLS_B,
        VPM_CLS_C,
        VPM_CLS_D,
        VPM_CLS_E,
        VPM_CLS_F,
        VPM_CLS_CTRL
    } vpm_cls_e;

endpackage

// ---- hw/vpm_tmr_if.sv ----
// link between the monitor and its delay timer
`timescale 1ns/10ps
interface vpm_tmr_if #(
    parameter int DW = 10
);
    logic          run;
    logic [DW-1:0] delay;
    logic          expired;
    logic [DW-1:0] elapsed;

    modport ctl (output run, output delay, input expired, input elapsed);
    modport tmr (input run, input delay, output expired, output elapsed);
endinterface

// ---- hw/vpm_timer.sv ----
// persistence timer counting whole seconds while a fault is present
`timescale 1ns/10ps
module vpm_timer #(
    parameter int SEC_CYC = 100000000,
    parameter int DW      = 10
) (
    input  wire logic  i_clk,
    input  wire logic  i_sys_rst,
    vpm_tmr_if.tmr     t_if
);
    localparam int PW = $clog2(SEC_CYC);

    logic [PW-1:0] pre_q;
    logic [DW-1:0] secs_q;
    logic          exp_q;
    logic          tick;

    assign tick = (pre_q == PW'(SEC_CYC - 1));

    // one-second prescaler, held at zero while idle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            pre_q <= '0;
        else if (!t_if.run || tick)
            pre_q <= '0;
        else
            pre_q <= pre_q + 1'b1;
    end

    // seconds count restarts from zero when the fault goes away
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            secs_q <= '0;
        else if (!t_if.run)
            secs_q <= '0; // [RQ11]
        else if (tick && !exp_q)
            secs_q <= secs_q + 1'b1;
    end

    // expiry once the count reaches the configured delay
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            exp_q <= 1'b0;
        else
            exp_q <= t_if.run && (secs_q >= t_if.delay); // [RQ10]
    end

    assign t_if.expired = exp_q;
    assign t_if.elapsed = secs_q;
endmodule

// ---- hw/vpm_top.sv ----
// voltage plausibility monitor with avalon-mm register access
//
// Notes on behaviour
// RQ1 - single-breaker, breaker A closed: fault when A and B flags differ
// RQ2 - same case: fault when flags agree but phase angle excessive
// RQ3 - with A and B okay, angle beyond plus or minus 10 degrees
// RQ4 - dual-breaker, breaker A closed: fault when A and aux flags differ
// RQ5 - dual-breaker, breaker B closed: fault when B and aux flags differ
// RQ6 - dual, both closed: three flags unequal, or agree with angle excessive
// RQ7 - only systems connected through closed breakers are compared
// RQ8 - on trigger assert mismatch command and show mismatch indication
// RQ9 - monitoring switch gates everything, defaults to off
// RQ10 - alarm after fault persists for delay of 1 to 999 s, default 30
// RQ11 - delay timer restarts from zero when fault vanishes early
// RQ12 - alarm carries class A to F or control, default B
// RQ13 - self-acknowledge clears alarm once fault no longer detected
// RQ14 - without self-acknowledge alarm latches until button or external ack; the code also clears it on a write to the ack register
// RQ15 - activation always: monitoring runs with no further condition
// RQ16 - activation lock: monitoring suspended once lock equation is true
// RQ17 - activation flag: monitoring only while selected logic flag true
`timescale 1ns/10ps
`include "vpm_defs.svh"
module vpm_top #(
    parameter int P_SEC_CYC = `VPM_SEC_NS / `VPM_CLK_NS
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_breaker_a,
    input  wire logic        i_breaker_b,
    input  wire logic        i_ok_sys_a,
    input  wire logic        i_ok_sys_b,
    input  wire logic        i_ok_aux,
    input  wire logic [8:0]  i_phase_angle,
    input  wire logic        i_lock_monitoring,
    input  wire logic [31:0] i_programmable_logic_flag,
    input  wire logic        i_ext_ack,
    input  wire logic        i_button_ack,
    output logic             o_mismatch,
    output logic      [2:0]  o_alarm_class,
    output logic             o_irq
);
    localparam int PIN_W = 49;

    // pin synchroniser stages and filtered copy
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] s1_q;
    logic [PIN_W-1:0] s2_q;
    logic [PIN_W-1:0] s3_q;
    logic [PIN_W-1:0] pin_q;

    // filtered pin fields
    logic              brk_a;
    logic              brk_b;
    logic              ok_a;
    logic              ok_b;
    logic              ok_aux;
    logic              lock_eq;
    logic              ext_ack;
    logic              btn_ack;
    logic [31:0]       lflag;
    logic signed [8:0] angle;

    // registers
    logic [31:0]            ctrl_q;
    logic [`VPM_DLY_W-1:0]  dly_q;
    logic [`VPM_NIRQ-1:0]   ist_q;
    logic [`VPM_NIRQ-1:0]   ien_q;
    logic                   sw_ack_q;

    // bus state
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        req;
    logic        acc_wr;
    logic [31:0] rd_mux;
    logic [31:0] ctrl_m;
    logic [31:0] dly_m;
    logic [31:0] iclr_m;
    logic [31:0] ien_m;

    // monitor state
    logic                 mon_on;
    logic                 act_ok;
    logic                 active;
    logic                 ph_exc;
    logic                 cond;
    logic                 fault_q;
    logic                 alarm_q;
    logic                 alarm_d;
    logic                 ack_any;
    logic                 irq_q;
    logic [2:0]           cls_q;
    logic [`VPM_NIRQ-1:0] iev;

    vpm_tmr_if #(.DW(`VPM_DLY_W)) tif ();

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] vpm_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // gather all input pins except clock, reset and the avalon bus into one vector
    assign pin_raw = {i_phase_angle, i_programmable_logic_flag,
                      i_button_ack, i_ext_ack, i_lock_monitoring,
                      i_ok_aux, i_ok_sys_b, i_ok_sys_a,
                      i_breaker_b, i_breaker_a};

    // three-stage synchroniser chain
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a pin change counts once stages two and three agree
    for (genvar gi = 0; gi < PIN_W; gi++) begin : g_pin
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst)
                pin_q[gi] <= 1'b0;
            else if (s2_q[gi] == s3_q[gi])
                pin_q[gi] <= s3_q[gi];
        end
    end

    // split the filtered vector
    assign brk_a   = pin_q[0];
    assign brk_b   = pin_q[1];
    assign ok_a    = pin_q[2];
    assign ok_b    = pin_q[3];
    assign ok_aux  = pin_q[4];
    assign lock_eq = pin_q[5];
    assign ext_ack = pin_q[6];
    assign btn_ack = pin_q[7];
    assign lflag   = pin_q[39:8];
    assign angle   = $signed(pin_q[48:40]);

    // bus handshake: waitrequest drops for one cycle per request
    assign req    = i_avs_read || i_avs_write;
    assign acc_wr = i_avs_write && !wait_q;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            wait_q <= 1'b1;
        else if (req && wait_q)
            wait_q <= 1'b0;
        else
            wait_q <= 1'b1;
    end

    // read mux; unmapped and write-only offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (i_avs_address == `VPM_A_CTRL)
            rd_mux = ctrl_q;
        else if (i_avs_address == `VPM_A_DELAY)
            rd_mux = {22'h00_0000, dly_q};
        else if (i_avs_address == `VPM_A_STATUS)
            rd_mux = {6'h00, tif.elapsed, 3'h0,
                      ok_aux, ok_b, ok_a, brk_b, brk_a,
                      3'h0, ph_exc, !act_ok, alarm_q, fault_q, active};
        else if (i_avs_address == `VPM_A_IRQ_STAT)
            rd_mux = {29'h0000_0000, ist_q};
        else if (i_avs_address == `VPM_A_IRQ_EN)
            rd_mux = {29'h0000_0000, ien_q};
    end

    // read data registered while waitrequest is still high
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            rdata_q <= 32'h0000_0000;
        else if (i_avs_read && wait_q)
            rdata_q <= rd_mux;
    end

    // merged write words
    assign ctrl_m = vpm_merge(ctrl_q, i_avs_writedata, i_avs_byteenable);
    assign dly_m  = vpm_merge({22'h00_0000, dly_q}, i_avs_writedata,
                              i_avs_byteenable);
    assign iclr_m = vpm_merge(32'h0000_0000, i_avs_writedata,
                              i_avs_byteenable);
    assign ien_m  = vpm_merge({29'h0000_0000, ien_q}, i_avs_writedata,
                              i_avs_byteenable);

    // control: monitor on, mode, self-ack, activation, flag, class
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            ctrl_q <= `VPM_CTRL_RST; // [RQ9] [RQ12] [RQ14] [RQ15]
        else if (acc_wr && i_avs_address == `VPM_A_CTRL)
            ctrl_q <= ctrl_m & `VPM_CTRL_MASK;
    end

    // delay setting, clamped into its legal range
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            dly_q <= `VPM_DLY_RST; // [RQ10]
        else if (acc_wr && i_avs_address == `VPM_A_DELAY) begin
            if (dly_m[31:10] != 22'h00_0000 ||
                dly_m[9:0] > `VPM_DLY_MAX)
                dly_q <= `VPM_DLY_MAX;
            else if (dly_m[9:0] < `VPM_DLY_MIN)
                dly_q <= `VPM_DLY_MIN;
            else
                dly_q <= dly_m[9:0];
        end
    end

    // software acknowledge pulse from the write-only register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            sw_ack_q <= 1'b0;
        else
            sw_ack_q <= acc_wr && i_avs_address == `VPM_A_ACK &&
                        iclr_m[0];
    end

    // interrupt enable register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            ien_q <= '0;
        else if (acc_wr && i_avs_address == `VPM_A_IRQ_EN)
            ien_q <= ien_m[`VPM_NIRQ-1:0];
    end

    // activation source selects when monitoring may run
    always_comb begin
        act_ok = 1'b1;
        case (vpm_pkg::vpm_act_e'(ctrl_q[`VPM_C_ACT]))
            vpm_pkg::VPM_ACT_ALWAYS: act_ok = 1'b1;       // [RQ15]
            vpm_pkg::VPM_ACT_LOCK:   act_ok = !lock_eq;   // [RQ16]
            vpm_pkg::VPM_ACT_FLAG:
                act_ok = lflag[ctrl_q[`VPM_C_FSEL]];      // [RQ17]
            default:                 act_ok = 1'b1;
        endcase
    end

    assign mon_on = ctrl_q[`VPM_C_ON];
    assign active = mon_on && act_ok; // [RQ9]

    // phase check only meaningful with both systems okay
    assign ph_exc = ok_a && ok_b &&
                    (angle > `VPM_PH_LIM || angle < -`VPM_PH_LIM); // [RQ3]

    // plausibility condition for the connected systems only
    always_comb begin
        cond = 1'b0;
        if (!ctrl_q[`VPM_C_DUAL]) begin
            if (brk_a)
                cond = (ok_a != ok_b) || ph_exc; // [RQ1] [RQ2] [RQ7]
        end else if (brk_a && brk_b) begin
            cond = (ok_a != ok_b) || (ok_a != ok_aux) ||
                   ph_exc;                       // [RQ6] [RQ7]
        end else if (brk_a) begin
            cond = (ok_a != ok_aux);             // [RQ4] [RQ7]
        end else if (brk_b) begin
            cond = (ok_b != ok_aux);             // [RQ5] [RQ7]
        end
    end

    // registered fault, evaluated only while monitoring is active
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            fault_q <= 1'b0;
        else
            fault_q <= active && cond; // [RQ9]
    end

    // timer runs while the fault persists
    assign tif.run   = fault_q;
    assign tif.delay = dly_q;

    vpm_timer #(
        .SEC_CYC (P_SEC_CYC),
        .DW      (`VPM_DLY_W)
    ) u_tmr (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .t_if      (tif.tmr)
    );

    // any acknowledge source
    assign ack_any = ext_ack || btn_ack || sw_ack_q;

    // alarm: set on expiry, cleared by self-ack or acknowledge
    always_comb begin
        alarm_d = alarm_q;
        if (!mon_on)
            alarm_d = 1'b0;                          // [RQ9]
        else if (tif.expired)
            alarm_d = 1'b1;                          // [RQ10]
        else if (!fault_q && ctrl_q[`VPM_C_SACK])
            alarm_d = 1'b0;                          // [RQ13]
        else if (!fault_q && ack_any)
            alarm_d = 1'b0;                          // [RQ14]
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            alarm_q <= 1'b0;
        else
            alarm_q <= alarm_d;
    end

    // command output follows the alarm state, class follows the control class field
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mismatch <= 1'b0;
            cls_q      <= 3'h0;
        end else begin
            o_mismatch <= alarm_d;                   // [RQ8]
            cls_q      <= ctrl_q[`VPM_C_CLS];        // [RQ12]
        end
    end

    // interrupt events: alarm raised, fault seen, alarm cleared
    always_comb begin
        iev = '0;
        iev[`VPM_I_RAISE] = alarm_d && !alarm_q;
        iev[`VPM_I_FAULT] = active && cond && !fault_q;
        iev[`VPM_I_CLEAR] = !alarm_d && alarm_q;
    end

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            ist_q <= '0;
        else if (acc_wr && i_avs_address == `VPM_A_IRQ_CLR)
            ist_q <= (ist_q & ~iclr_m[`VPM_NIRQ-1:0]) | iev;
        else
            ist_q <= ist_q | iev;
    end

    // level interrupt while any enabled status bit is set
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            irq_q <= 1'b0;
        else
            irq_q <= |(ist_q & ien_q);
    end

    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_alarm_class     = cls_q;
    assign o_irq             = irq_q;
endmodule

// ---- tb/vpm_properties.sv ----
// bus and alarm properties of the plausibility monitor
`timescale 1ns/10ps
module vpm_chk #(
    parameter int P_SEC_CYC = 20
) (
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_breaker_a,
    input wire logic        i_breaker_b,
    input wire logic        o_mismatch,
    input wire logic [2:0]  o_alarm_class
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // bus answers only requests, one wait cycle, one cycle low
    property p_wait_cause;
        !o_avs_waitrequest |-> $past(i_avs_read || i_avs_write);
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("stray ready");
    property p_wait_one;
        !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("ready too long");
    property p_wait_ans;
        (i_avs_read || i_avs_write) && o_avs_waitrequest
            |=> !o_avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("late answer");
    property p_rd_hold;
        !$stable(o_avs_readdata) |-> $past(i_avs_read) || $past(i_sys_rst);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
    // class is a legal code and moves only after a write
    property p_cls_range;
        o_alarm_class <= 3'h6;
    endproperty
    a_cls_range: assert property (p_cls_range)
        else $error("bad class");
    // class reloads from the reset value on the first edge after release
    property p_cls_cause;
        !$stable(o_alarm_class) |-> $past(i_sys_rst) ||
            $past(i_sys_rst, 2) ||
            $past(i_avs_write && !o_avs_waitrequest) ||
            $past(i_avs_write && !o_avs_waitrequest, 2);
    endproperty
    a_cls_cause: assert property (p_cls_cause)
        else $error("class moved");
    // alarm needs a closed breaker sampled 8 cycles and one second before it rises
    property p_mm_conn;
        $rose(o_mismatch) |-> $past(i_breaker_a || i_breaker_b, 8);
    endproperty
    a_mm_conn: assert property (p_mm_conn)
        else $error("alarm unlinked");
    property p_mm_persist;
        $rose(o_mismatch) |-> $past(i_breaker_a || i_breaker_b, P_SEC_CYC);
    endproperty
    a_mm_persist: assert property (p_mm_persist)
        else $error("alarm early");
    c_raise: cover property ($rose(o_mismatch));
    c_clear: cover property ($fell(o_mismatch));
    c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule

bind vpm_top vpm_chk #(.P_SEC_CYC(P_SEC_CYC)) i_vpm_chk (
    .i_clk             (i_clk),
    .i_sys_rst         (i_sys_rst),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .i_breaker_a       (i_breaker_a),
    .i_breaker_b       (i_breaker_b),
    .o_mismatch        (o_mismatch),
    .o_alarm_class     (o_alarm_class)
);

// ---- tb/vpm_field.sv ----
// field model: breaker feedbacks, voltage flags, angle and ack button
`timescale 1ns/10ps
module vpm_field (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [5:0] i_cmd,
    input  wire logic [8:0] i_ang,
    output logic            o_breaker_a,
    output logic            o_breaker_b,
    output logic            o_ok_a,
    output logic            o_ok_b,
    output logic            o_ok_aux,
    output logic            o_button,
    output logic      [8:0] o_ang
);
    // plant settles one clock after a command; press is a held level
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {o_breaker_a, o_breaker_b, o_ok_a, o_ok_b, o_ok_aux} <= 5'h00;
            o_button <= 1'b0;
            o_ang    <= 9'h000;
        end else begin
            {o_breaker_a, o_breaker_b, o_ok_a, o_ok_b, o_ok_aux} <= i_cmd[5:1];
            o_button <= i_cmd[0];
            o_ang    <= i_ang;
        end
    end
endmodule

// ---- tb/voltage_plausibility_monitor_tb.sv ----
// self-checking bench for the voltage plausibility monitor
`timescale 1ns/10ps
`include "vpm_defs.svh"
module voltage_plausibility_monitor_tb;
    logic              clk, rst, rd, wr, eack, lock;
    logic        [7:0] adr;
    logic       [31:0] wd, flg, q;
    logic        [5:0] cmd;
    logic        [8:0] ang;
    logic        [3:0] be;
    wire logic  [31:0] rdata;
    wire logic         wreq, bka, bkb, oka, okb, okx, bak, mm, irq;
    wire logic   [8:0] pha;
    wire logic   [2:0] cls;
    int                failures, n_tests, n, i;
    logic        [6:0] tm [12];
    logic        [8:0] ta [12];

    vpm_top #(.P_SEC_CYC(20)) i_vpm_top (
        .i_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_breaker_a(bka), .i_breaker_b(bkb),
        .i_ok_sys_a(oka), .i_ok_sys_b(okb), .i_ok_aux(okx),
        .i_phase_angle(pha), .i_lock_monitoring(lock),
        .i_programmable_logic_flag(flg), .i_ext_ack(eack),
        .i_button_ack(bak), .o_mismatch(mm), .o_alarm_class(cls),
        .o_irq(irq));
    vpm_field i_vpm_field (
        .i_clk(clk), .i_rst(rst), .i_cmd(cmd), .i_ang(ang),
        .o_breaker_a(bka), .o_breaker_b(bkb), .o_ok_a(oka), .o_ok_b(okb),
        .o_ok_aux(okx), .o_button(bak), .o_ang(pha));

    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        failures++;
        report_and_stop();
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e, input string s);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, s, g, e);
        end
    endtask
    // one avalon transfer; held until the rising edge that sees ready,
    // read data lands in q at that same edge; the watchdog ends a hang
    task automatic av(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        do begin
            @(posedge clk);
            k++;
        end while (wreq !== 1'b0);
        chk({31'h0, k > 1}, 32'h1, "no wait state");
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, e,
                      input string s);
        av(1'b0, a, 32'h0);
        chk(q & m, e, s);
    endtask
    task automatic fld(input logic [5:0] c, input logic [8:0] g);
        cmd <= c;
        ang <= g;
        repeat (14) @(posedge clk);
    endtask
    // bounded wait on the alarm level, ends right after a rising edge
    task automatic wmm(input logic v, input int lim);
        n = 0;
        while (mm !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask

    // fault table: dual, brk a, brk b, ok a, ok b, ok aux, expected
    initial begin
        tm = '{7'h29, 7'h2D, 7'h2C, 7'h2D, 7'h18, 7'h6D,
               7'h5B, 7'h6A, 7'h7D, 7'h7F, 7'h7E, 7'h20};
        ta = '{9'h000, 9'h00B, 9'h00A, 9'h1F5, 9'h000, 9'h000,
               9'h000, 9'h000, 9'h000, 9'h014, 9'h000, 9'h014};
        {rd, wr, eack, lock} = 4'h0;
        {adr, wd, flg, cmd, ang} = '0;
        be = 4'hF;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(`VPM_A_CTRL, 32'hFFFFFFFF, 32'h00010000, "ctrl rst");
        rc(`VPM_A_DELAY, 32'hFFFFFFFF, 32'h0000001E, "delay rst");
        rc(8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped");
        rc(`VPM_A_IRQ_EN, 32'hFFFFFFFF, 32'h0, "irq en rst");
        chk({29'h0, cls}, 32'h1, "class rst");
        av(1'b1, `VPM_A_DELAY, 32'h0);
        rc(`VPM_A_DELAY, 32'h3FF, 32'h1, "delay min");
        av(1'b1, `VPM_A_DELAY, 32'h3FF);
        rc(`VPM_A_DELAY, 32'h3FF, 32'h3E7, "delay max");
        // only the low byte lane is written, upper lanes keep their bits
        be <= 4'h1;
        av(1'b1, `VPM_A_DELAY, 32'hFFFF_FF05);
        be <= 4'hF;
        rc(`VPM_A_DELAY, 32'h3FF, 32'h305, "byte lane");
        av(1'b1, `VPM_A_DELAY, 32'h5);
        fld(6'h28, 9'h0);
        repeat (60) @(posedge clk);
        rc(`VPM_A_STATUS, 32'h2, 32'h0, "off fault");
        chk({31'h0, mm}, 32'h0, "off alarm");
        for (i = 0; i < 12; i++) begin
            av(1'b1, `VPM_A_CTRL, {30'h0, tm[i][6], 1'b1});
            fld({tm[i][5:1], 1'b0}, ta[i]);
            rc(`VPM_A_STATUS, 32'h2, {30'h0, tm[i][0], 1'b0}, "case");
        end
        // latched alarm, restart of the delay, acknowledge paths
        av(1'b1, `VPM_A_CTRL, 32'h00000000);
        fld(6'h2C, 9'h0);
        av(1'b1, `VPM_A_CTRL, 32'h00030001);
        av(1'b1, `VPM_A_DELAY, 32'h2);
        av(1'b1, `VPM_A_IRQ_CLR, 32'h7);
        av(1'b1, `VPM_A_IRQ_EN, 32'h7);
        cmd <= 6'h28;
        repeat (25) @(posedge clk);
        cmd <= 6'h2C;
        repeat (10) @(posedge clk);
        cmd <= 6'h28;
        repeat (30) @(posedge clk);
        chk({31'h0, mm}, 32'h0, "restart");
        wmm(1'b1, 60);
        chk({31'h0, n > 8 && n < 30}, 32'h1, "delay");
        chk({29'h0, cls}, 32'h3, "class");
        chk({30'h0, mm, irq}, 32'h3, "alarm irq");
        rc(`VPM_A_IRQ_STAT, 32'h3, 32'h3, "stat raise");
        av(1'b1, `VPM_A_ACK, 32'h1);
        fld(6'h2C, 9'h0);
        chk({31'h0, mm}, 32'h0000001, "latched");
        fld(6'h2D, 9'h0);
        cmd <= 6'h2C;
        wmm(1'b0, 20);
        chk({31'h0, mm}, 32'h0, "button");
        rc(`VPM_A_IRQ_STAT, 32'h4, 32'h4, "stat clear");
        av(1'b1, `VPM_A_IRQ_CLR, 32'h7);
        rc(`VPM_A_IRQ_STAT, 32'h7, 32'h0, "stat w1c");
        av(1'b1, `VPM_A_IRQ_EN, 32'h0);
        cmd <= 6'h28;
        wmm(1'b1, 80);
        chk({30'h0, mm, irq}, 32'h2, "masked");
        fld(6'h2C, 9'h0);
        eack <= 1'b1;
        repeat (8) @(posedge clk);
        eack <= 1'b0;
        wmm(1'b0, 20);
        chk({31'h0, mm}, 32'h0, "ext ack");
        av(1'b1, `VPM_A_CTRL, 32'h00010005);
        cmd <= 6'h28;
        wmm(1'b1, 80);
        cmd <= 6'h2C;
        wmm(1'b0, 15);
        chk({31'h0, mm}, 32'h0, "self ack");
        // activation sources
        av(1'b1, `VPM_A_CTRL, 32'h00010011);
        lock <= 1'b1;
        fld(6'h28, 9'h0);
        rc(`VPM_A_STATUS, 32'h2, 32'h0, "locked");
        lock <= 1'b0;
        fld(6'h28, 9'h0);
        rc(`VPM_A_STATUS, 32'h2, 32'h2, "unlocked");
        av(1'b1, `VPM_A_CTRL, 32'h00010521);
        flg <= 32'h10;
        fld(6'h28, 9'h0);
        rc(`VPM_A_STATUS, 32'h2, 32'h0, "flag off");
        flg <= 32'h20;
        fld(6'h28, 9'h0);
        rc(`VPM_A_STATUS, 32'h2, 32'h2, "flag on");
        av(1'b1, `VPM_A_CTRL, 32'h00010001);
        lock <= 1'b1;
        fld(6'h28, 9'h0);
        rc(`VPM_A_STATUS, 32'h2, 32'h2, "always");
        report_and_stop();
    end
endmodule
